// [logic/sltc_pat_if.sv]
// Carrier between the control top and the test pattern generator.
// Assumes both ends run on the same reference clock.
`timescale 1ns/10ps
`default_nettype none
interface sltc_pat_if;
  logic [3:0] mode;
  logic [15:0] user;
  logic [15:0] word;
  logic single_done;
  modport gen (input mode, input user, output word, output single_done);
  modport use_side (output mode, output user, input word, input single_done);
endinterface
`default_nettype wire

// [logic/sltc_pattern.sv]
// Test pattern generator: one 16-bit word per clock for the selected code.
// Assumes the mode is a registered control value on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sltc_pattern (
  input wire logic REF_CLK,
  input wire logic RST_N,
  sltc_pat_if.gen pat
);
  import sltc_pkg::*;

  typedef struct packed {
    logic [30:0] lfsr;
    logic [15:0] word;
    logic [15:0] ramp;
    logic [3:0] mode_q;
    logic done;
  } sltc_pat_regs_t;

  sltc_pat_regs_t r;
  sltc_pat_regs_t nxt;

  // ---------------------------------------------------------------------------
  // Sixteen serial steps of a Fibonacci shift register of width w, tap t.
  // ---------------------------------------------------------------------------
  function automatic logic [46:0] pn_step(logic [30:0] s, int w, int t);
    logic [30:0] v;
    logic [30:0] mask;
    logic [15:0] o;
    logic fb;
    v = s;
    mask = LFSR_SEED >> (LFSR_W - w);
    o = '0;
    fb = 1'b0;
    for (int i = 0; i < PAT_W; i++) begin
      fb = v[w-1] ^ v[t-1];
      v = {v[29:0], fb} & mask;
      o = {o[14:0], fb};
    end
    return {v, o};
  endfunction

  always_comb begin
    logic [30:0] base;
    logic [46:0] st;
    base = (pat.mode != r.mode_q) ? LFSR_SEED : r.lfsr;
    st = '0;
    nxt = r;
    nxt.mode_q = pat.mode;
    nxt.ramp = r.ramp + 16'h0001;
    case (pat.mode)
      TP_PN31: st = pn_step(base, 31, 28);
      TP_PN23: st = pn_step(base, 23, 18);
      TP_PN15: st = pn_step(base, 15, 14);
      TP_PN9: st = pn_step(base, 9, 5);
      TP_PN7: st = pn_step(base, 7, 6);
      default: st = {base, 16'h0000};
    endcase
    nxt.lfsr = st[46:16];
    case (pat.mode)
      TP_CHECKER: nxt.word = (r.word == CHECKER_A) ? ~CHECKER_A : CHECKER_A;
      TP_TOGGLE: nxt.word = (r.word == WORD_ONES) ? 16'h0000 : WORD_ONES;
      TP_PN31, TP_PN23, TP_PN15, TP_PN9, TP_PN7: nxt.word = st[15:0];
      TP_RAMP: nxt.word = r.ramp;
      TP_USER_REP: nxt.word = pat.user;
      TP_USER_ONE: begin
        nxt.word = r.done ? 16'h0000 : pat.user;
        nxt.done = 1'b1;
      end
      default: nxt.word = 16'h0000;
    endcase
    if (pat.mode != TP_USER_ONE) begin
      nxt.done = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '{lfsr: LFSR_SEED, default: '0};
    end else begin
      r <= nxt;
    end
  end

  assign pat.word = r.word;
  assign pat.single_done = r.done;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_pn7_recur;
    (pat.mode == TP_PN7) ##1 ($past(pat.mode) == TP_PN7) |->
      pat.word[8:0] == (pat.word[15:7] ^ pat.word[14:6]);
  endproperty
  a_pn7_recur: assert property (p_pn7_recur) else $error("PN7 word breaks recurrence");

  property p_pn9_recur;
    $past(pat.mode) == TP_PN9 |-> pat.word[6:0] == (pat.word[15:9] ^ pat.word[11:5]);
  endproperty
  a_pn9_recur: assert property (p_pn9_recur) else $error("PN9 word breaks recurrence");

  property p_pn15_recur;
    $past(pat.mode) == TP_PN15 |-> pat.word[0] == (pat.word[15] ^ pat.word[14]);
  endproperty
  a_pn15_recur: assert property (p_pn15_recur) else $error("PN15 word breaks recurrence");

  property p_checker;
    (pat.mode == TP_CHECKER)[*2] |=> pat.word == ~$past(pat.word) &&
      (pat.word == CHECKER_A || pat.word == ~CHECKER_A);
  endproperty
  a_checker: assert property (p_checker) else $error("checkerboard did not alternate");
endmodule
`default_nettype wire

// [logic/sltc_pkg.sv]
// Constants, field positions and types for the link transmit coding control.
// Assumes a byte-wide register port and one 40 MHz reference clock.
package sltc_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_LINK_CTRL = 16'h0571;
  localparam logic [15:0] ADDR_ENC_OPT = 16'h0572;
  localparam logic [15:0] ADDR_CKSUM_TEST = 16'h0573;
  localparam logic [15:0] ADDR_ALIGN_DLY = 16'h0574;
  localparam logic [15:0] ADDR_USER_LO = 16'h05F0;
  localparam logic [15:0] ADDR_USER_HI = 16'h05F1;
  localparam logic [15:0] ADDR_STATUS = 16'h05F2;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;
  localparam logic [7:0] RST_ENC_OPT = 8'h00;
  localparam logic [7:0] RST_CKSUM_TEST = 8'h00;
  localparam logic [3:0] RST_ALIGN_DLY = 4'h0;
  localparam logic [15:0] RST_USER = 16'h0000;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LINK_DOWN_BIT = 0;
  localparam int SYNC_INV_BIT = 5;
  localparam int BYPASS_BIT = 2;
  localparam int INVERT_BIT = 1;
  localparam int ENC_RSVD_BIT = 0;
  localparam int CKS_MODE_LO = 6;
  localparam int INJ_LO = 4;
  localparam int TP_LO = 0;
  localparam int DLY_LO = 4;
  localparam int ST_CGS_BIT = 0;
  localparam int ST_WAIT_BIT = 1;
  localparam int ST_DATA_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  // ---------------------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CKS_OCTETS = 2'b00;
  localparam logic [1:0] CKS_FIELDS = 2'b01;
  localparam logic [1:0] CKS_ZERO = 2'b10;
  localparam logic [1:0] INJ_SAMPLE = 2'b00;
  localparam logic [1:0] INJ_SYMBOL = 2'b01;
  localparam logic [1:0] INJ_SCRAMBLER = 2'b10;
  localparam logic [3:0] TP_OFF = 4'h0;
  localparam logic [3:0] TP_CHECKER = 4'h1;
  localparam logic [3:0] TP_TOGGLE = 4'h2;
  localparam logic [3:0] TP_PN31 = 4'h3;
  localparam logic [3:0] TP_PN23 = 4'h4;
  localparam logic [3:0] TP_PN15 = 4'h5;
  localparam logic [3:0] TP_PN9 = 4'h6;
  localparam logic [3:0] TP_PN7 = 4'h7;
  localparam logic [3:0] TP_RAMP = 4'h8;
  localparam logic [3:0] TP_USER_REP = 4'hE;
  localparam logic [3:0] TP_USER_ONE = 4'hF;
  // ---------------------------------------------------------------------------
  // Data widths and pattern constants
  // ---------------------------------------------------------------------------
  localparam int PAT_W = 16;
  localparam int SYM_W = 10;
  localparam int LCT_OCTETS = 13;
  localparam int LFSR_W = 31;
  localparam logic [15:0] CHECKER_A = 16'hAAAA;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [30:0] LFSR_SEED = 31'h7FFF_FFFF;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_CGS = 2'b01,
    ST_WAIT = 2'b11,
    ST_DATA = 2'b10
  } sltc_state_t;
endpackage

// [logic/sltc_top.sv]
// Transmit coding control: encoder options, alignment checksum, test data
// injection and the wait for the alignment start after sync release.
// Assumes LMFC_EDGE is a one-cycle pulse on REF_CLK and the sync pin is async.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
module sltc_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [sltc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic SYNC_REQUEST_INPUT_N,
  input wire logic LMFC_EDGE,
  input wire logic [8*sltc_pkg::LCT_OCTETS-1:0] CFG_OCTETS,
  input wire logic [sltc_pkg::PAT_W-1:0] SMP_DATA,
  input wire logic [7:0] SCR_DATA,
  input wire logic [7:0] ENC_BYTE,
  input wire logic [sltc_pkg::SYM_W-1:0] ENC_SYM,
  output logic [sltc_pkg::PAT_W-1:0] SMP_OUT,
  output logic [7:0] SCR_OUT,
  output logic [sltc_pkg::SYM_W-1:0] SYM_OUT,
  output logic SEND_CGS,
  output logic ILAS_START,
  output logic [7:0] CHECKSUM
);
  import sltc_pkg::*;

  typedef struct packed {
    logic link_down;
    logic [7:0] enc_opt;
    logic [7:0] cks_cfg;
    logic [3:0] dly;
    logic [15:0] user;
    logic [7:0] rdata;
    logic sync_s1;
    logic sync_s2;
    sltc_state_t st;
    logic [3:0] lmfc_cnt;
    logic send_cgs;
    logic ilas_start;
    logic [7:0] cksum;
    logic [15:0] smp_out;
    logic [7:0] scr_out;
    logic [9:0] sym_out;
  } sltc_top_regs_t;

  sltc_top_regs_t r;
  sltc_top_regs_t nxt;
  sltc_pat_if pat ();

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] octet(logic [103:0] tbl, int i);
    return tbl[8*i +: 8];
  endfunction

  function automatic logic [7:0] fld(logic [103:0] tbl, int i, int hi, int lo);
    logic [8:0] mask;
    mask = 9'((9'h001 << (hi - lo + 1)) - 9'h001);
    return 8'(octet(tbl, i) >> lo) & mask[7:0];
  endfunction

  function automatic logic [7:0] octet_sum(logic [103:0] tbl);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < LCT_OCTETS; i++) begin
      s = s + octet(tbl, i);
    end
    return s;
  endfunction

  // Each field of the link table, zero-extended from its own least bit.
  function automatic logic [7:0] field_sum(logic [103:0] t);
    return fld(t, 0, 7, 0) + fld(t, 1, 3, 0) + fld(t, 1, 7, 4) + fld(t, 2, 4, 0)
      + fld(t, 2, 5, 5) + fld(t, 2, 6, 6) + fld(t, 3, 4, 0) + fld(t, 3, 7, 7)
      + fld(t, 4, 7, 0) + fld(t, 5, 4, 0) + fld(t, 6, 7, 0) + fld(t, 7, 7, 6)
      + fld(t, 7, 4, 0) + fld(t, 8, 4, 0) + fld(t, 8, 7, 5) + fld(t, 9, 4, 0)
      + fld(t, 9, 7, 5) + fld(t, 10, 4, 0) + fld(t, 10, 7, 7);
  endfunction

  // ---------------------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------------------
  logic [1:0] cks_mode;
  logic [1:0] inj;
  logic [3:0] tp;
  logic sync_req;
  logic test_on;

  assign cks_mode = r.cks_cfg[CKS_MODE_LO +: 2];
  assign inj = r.cks_cfg[INJ_LO +: 2];
  assign tp = r.cks_cfg[TP_LO +: 4];
  assign test_on = (tp != TP_OFF);
  // The pin is active low; the invert bit flips the sense before use.
  assign sync_req = ~r.sync_s2 ^ r.enc_opt[SYNC_INV_BIT];
  assign pat.mode = tp;
  assign pat.user = r.user;

  sltc_pattern u_pattern (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .pat(pat.gen)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [9:0] sym;
    nxt = r;
    sym = '0;
    // Register port: writes take effect at the strobe edge.
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_LINK_CTRL: nxt.link_down = REG_WDATA[LINK_DOWN_BIT];
        ADDR_ENC_OPT: begin
          nxt.enc_opt = 8'h00;
          nxt.enc_opt[SYNC_INV_BIT] = REG_WDATA[SYNC_INV_BIT];
          nxt.enc_opt[BYPASS_BIT] = REG_WDATA[BYPASS_BIT];
          nxt.enc_opt[INVERT_BIT] = REG_WDATA[INVERT_BIT];
          nxt.enc_opt[ENC_RSVD_BIT] = REG_WDATA[ENC_RSVD_BIT];
        end
        ADDR_CKSUM_TEST: nxt.cks_cfg = REG_WDATA;
        ADDR_ALIGN_DLY: nxt.dly = REG_WDATA[DLY_LO +: 4];
        ADDR_USER_LO: nxt.user[7:0] = REG_WDATA;
        ADDR_USER_HI: nxt.user[15:8] = REG_WDATA;
        default: nxt.user = r.user;
      endcase
    end
    nxt.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_LINK_CTRL: nxt.rdata[LINK_DOWN_BIT] = r.link_down;
        ADDR_ENC_OPT: nxt.rdata = r.enc_opt;
        ADDR_CKSUM_TEST: nxt.rdata = r.cks_cfg;
        ADDR_ALIGN_DLY: nxt.rdata = {r.dly, 4'h0};
        ADDR_USER_LO: nxt.rdata = r.user[7:0];
        ADDR_USER_HI: nxt.rdata = r.user[15:8];
        ADDR_STATUS: begin
          nxt.rdata[ST_CGS_BIT] = r.send_cgs;
          nxt.rdata[ST_WAIT_BIT] = (r.st == ST_WAIT);
          nxt.rdata[ST_DATA_BIT] = (r.st == ST_DATA);
          nxt.rdata[ST_DONE_BIT] = pat.single_done;
        end
        default: nxt.rdata = 8'h00;
      endcase
    end
    // Two-flop synchroniser on the sync request pin.
    nxt.sync_s1 = SYNC_REQUEST_INPUT_N;
    nxt.sync_s2 = r.sync_s1;
    // Link state: sync characters, then the wait for the LMFC boundary.
    nxt.ilas_start = 1'b0;
    case (r.st)
      ST_OFF: begin
        if (!r.link_down) begin
          nxt.st = ST_CGS;
        end
      end
      ST_CGS: begin
        if (!sync_req) begin
          nxt.st = ST_WAIT;
          nxt.lmfc_cnt = 4'h0;
        end
      end
      ST_WAIT: begin
        if (sync_req) begin
          nxt.st = ST_CGS;
        end else if (LMFC_EDGE) begin
          if (r.lmfc_cnt == r.dly) begin
            nxt.st = ST_DATA;
            nxt.ilas_start = 1'b1;
          end else begin
            nxt.lmfc_cnt = r.lmfc_cnt + 4'h1;
          end
        end
      end
      ST_DATA: begin
        if (sync_req) begin
          nxt.st = ST_CGS;
        end
      end
      default: nxt.st = ST_OFF;
    endcase
    if (r.link_down) begin
      nxt.st = ST_OFF;
      nxt.ilas_start = 1'b0;
    end
    nxt.send_cgs = !r.link_down && sync_req;
    // Alignment checksum.
    case (cks_mode)
      CKS_OCTETS: nxt.cksum = octet_sum(CFG_OCTETS);
      CKS_FIELDS: nxt.cksum = field_sum(CFG_OCTETS);
      default: nxt.cksum = 8'h00;
    endcase
    // Data path with test injection at the selected point.
    nxt.smp_out = (test_on && inj == INJ_SAMPLE) ? pat.word : SMP_DATA;
    nxt.scr_out = (test_on && inj == INJ_SCRAMBLER) ? pat.word[7:0] : SCR_DATA;
    if (test_on && inj == INJ_SYMBOL) begin
      sym = pat.word[9:0];
    end else if (r.enc_opt[BYPASS_BIT]) begin
      sym = {2'b00, ENC_BYTE};
    end else begin
      sym = ENC_SYM;
    end
    nxt.sym_out = r.enc_opt[INVERT_BIT] ? ~sym : sym;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '{
        link_down: RST_LINK_CTRL[LINK_DOWN_BIT],
        enc_opt: RST_ENC_OPT,
        cks_cfg: RST_CKSUM_TEST,
        dly: RST_ALIGN_DLY,
        user: RST_USER,
        sync_s1: 1'b1,
        sync_s2: 1'b1,
        st: ST_OFF,
        default: '0
      };
    end else begin
      r <= nxt;
    end
  end

  assign REG_RDATA = r.rdata;
  assign SMP_OUT = r.smp_out;
  assign SCR_OUT = r.scr_out;
  assign SYM_OUT = r.sym_out;
  assign SEND_CGS = r.send_cgs;
  assign ILAS_START = r.ilas_start;
  assign CHECKSUM = r.cksum;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_bypass;
    (r.enc_opt[BYPASS_BIT] && !r.enc_opt[INVERT_BIT] && !(test_on && inj == INJ_SYMBOL))
      |=> SYM_OUT == {2'b00, $past(ENC_BYTE)};
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass symbol wrong");

  property p_invert;
    (r.enc_opt[INVERT_BIT] && !r.enc_opt[BYPASS_BIT] && !test_on)
      |=> SYM_OUT == ~$past(ENC_SYM);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted symbol wrong");

  property p_cks_zero;
    cks_mode == CKS_ZERO |=> CHECKSUM == 8'h00;
  endproperty
  a_cks_zero: assert property (p_cks_zero) else $error("checksum not zero");

  property p_ilas;
    $rose(ILAS_START) |-> $past(r.st == ST_WAIT && LMFC_EDGE && r.lmfc_cnt == r.dly)
      ##1 !ILAS_START;
  endproperty
  a_ilas: assert property (p_ilas) else $error("alignment start at wrong boundary");

  property p_cgs_plain;
    (!r.link_down && !r.sync_s2 && !r.enc_opt[SYNC_INV_BIT]) |=> SEND_CGS;
  endproperty
  a_cgs_plain: assert property (p_cgs_plain) else $error("no sync chars on request");

  property p_cgs_inv;
    (!r.link_down && r.sync_s2 && r.enc_opt[SYNC_INV_BIT]) |=> SEND_CGS ##1 1'b1;
  endproperty
  a_cgs_inv: assert property (p_cgs_inv) else $error("inverted request ignored");

  property p_inject_smp;
    (test_on && inj == INJ_SAMPLE) |=> SMP_OUT == $past(pat.word);
  endproperty
  a_inject_smp: assert property (p_inject_smp) else $error("sample not replaced");

  property p_normal;
    !test_on |=> SMP_OUT == $past(SMP_DATA) && SCR_OUT == $past(SCR_DATA);
  endproperty
  a_normal: assert property (p_normal) else $error("normal data not restored");

  property p_inject_scr;
    (test_on && inj == INJ_SCRAMBLER) |=> SCR_OUT == $past(pat.word[7:0]);
  endproperty
  a_inject_scr: assert property (p_inject_scr) else $error("scrambler input not replaced");

  property p_inject_sym;
    (test_on && inj == INJ_SYMBOL && !r.enc_opt[INVERT_BIT])
      |=> SYM_OUT == $past(pat.word[9:0]);
  endproperty
  a_inject_sym: assert property (p_inject_sym) else $error("symbol not replaced");

  property p_bypass_inv;
    (r.enc_opt[BYPASS_BIT] && r.enc_opt[INVERT_BIT] && !(test_on && inj == INJ_SYMBOL))
      |=> SYM_OUT == ~{2'b00, $past(ENC_BYTE)};
  endproperty
  a_bypass_inv: assert property (p_bypass_inv) else $error("inverted bypass symbol wrong");

  property p_cks_hi;
    cks_mode[1] |=> CHECKSUM == 8'h00;
  endproperty
  a_cks_hi: assert property (p_cks_hi) else $error("checksum not zero in upper modes");

  property p_link_down;
    r.link_down |=> !SEND_CGS && !ILAS_START;
  endproperty
  a_link_down: assert property (p_link_down) else $error("powered-down link still active");

  property p_wait_entry;
    (r.st == ST_CGS && !sync_req && !r.link_down)
      |=> r.st == ST_WAIT && r.lmfc_cnt == 4'h0;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait not entered on release");

  property p_count_step;
    (r.st == ST_WAIT && LMFC_EDGE && !sync_req && !r.link_down && r.lmfc_cnt != r.dly)
      |=> r.lmfc_cnt == $past(r.lmfc_cnt) + 4'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("boundary count did not step");

  property p_cgs_return;
    (sync_req && !r.link_down) |=> r.st == ST_CGS;
  endproperty
  a_cgs_return: assert property (p_cgs_return) else $error("request did not return to sync");

  property p_scr_normal;
    (inj != INJ_SCRAMBLER) |=> SCR_OUT == $past(SCR_DATA);
  endproperty
  a_scr_normal: assert property (p_scr_normal) else $error("scrambler byte replaced");
endmodule
`default_nettype wire

// [verif/sltc_rx_model.sv]
// Receiver-side model: drives the active-low sync request pin of the link.
// Assumes the bench raises want_sync whenever the receiver wants sync characters.
`timescale 1ns/10ps
`default_nettype none
module sltc_rx_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want_sync,
  output logic sync_n
);
  // The receiver asks for synchronization from reset until told otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_n <= 1'b0;
    end else begin
      sync_n <= ~want_sync;
    end
  end
endmodule
`default_nettype wire

// [verif/sltc_top_tb.sv]
// Self-checking bench for the link transmit coding control.
// Assumes one 40 MHz clock and the receiver model on the sync request pin.
`timescale 1ns/10ps
`default_nettype none
module sltc_top_tb;
  import sltc_pkg::*;
  logic clk, rst_n, wr, rd, lmfc, want_sync, sync_n, send_cgs, ilas;
  logic [15:0] addr, smp_data, smp_out;
  logic [7:0] wdata, rdata, scr_data, enc_byte, scr_out, cks;
  logic [9:0] enc_sym, sym_out;
  logic [103:0] cfg;
  int miscompares, num_checks;

  sltc_top u_sltc_top (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .SYNC_REQUEST_INPUT_N(sync_n), .LMFC_EDGE(lmfc),
    .CFG_OCTETS(cfg), .SMP_DATA(smp_data), .SCR_DATA(scr_data), .ENC_BYTE(enc_byte),
    .ENC_SYM(enc_sym), .SMP_OUT(smp_out), .SCR_OUT(scr_out), .SYM_OUT(sym_out),
    .SEND_CGS(send_cgs), .ILAS_START(ilas), .CHECKSUM(cks)
  );
  sltc_rx_model u_sltc_rx_model (
    .clk(clk), .rst_n(rst_n), .want_sync(want_sync), .sync_n(sync_n)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle right after the strobe.
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  function automatic logic [15:0] tap(input logic [1:0] inj);
    if (inj == INJ_SYMBOL) return {6'h00, sym_out};
    if (inj == INJ_SCRAMBLER) return {8'h00, scr_out};
    return smp_out;
  endfunction

  // Two successive words must be v0 and its inverse, in either phase.
  task automatic alt(input logic [1:0] inj, input logic [3:0] tp, input logic [15:0] v0);
    logic [15:0] m, a, b;
    m = (inj == INJ_SAMPLE) ? 16'hFFFF : (inj == INJ_SYMBOL) ? 16'h03FF : 16'h00FF;
    wr_reg(ADDR_CKSUM_TEST, {2'b00, inj, tp});
    tick(4);
    a = tap(inj);
    tick(1);
    b = tap(inj);
    chk(a, (a === (v0 & m)) ? (v0 & m) : (~v0 & m));
    chk(a ^ b, m);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rchk(ADDR_CKSUM_TEST, RST_CKSUM_TEST);
    rchk(ADDR_ALIGN_DLY, {RST_ALIGN_DLY, 4'h0});
    rchk(ADDR_ENC_OPT, RST_ENC_OPT);
    wr_reg(ADDR_CKSUM_TEST, 8'h65);
    rchk(ADDR_CKSUM_TEST, 8'h65);
    wr_reg(ADDR_ALIGN_DLY, 8'h9F);
    rchk(ADDR_ALIGN_DLY, 8'h90);
    wr_reg(ADDR_ENC_OPT, 8'hFF);
    rchk(ADDR_ENC_OPT, 8'h27);
    rchk(16'h0600, 8'h00);
    wr_reg(ADDR_ENC_OPT, 8'h00);
    wr_reg(ADDR_CKSUM_TEST, 8'h00);
    $display("register test done");
  endtask

  task automatic t_sym();
    logic [9:0] e;
    for (int o = 0; o < 4; o++) begin
      wr_reg(ADDR_ENC_OPT, {5'h00, o[1], o[0], 1'b0});
      tick(3);
      e = o[1] ? {2'b00, enc_byte} : enc_sym;
      if (o[0]) e = ~e;
      chk({6'h00, sym_out}, {6'h00, e});
    end
    wr_reg(ADDR_ENC_OPT, 8'h00);
    $display("encoder option test done");
  endtask

  task automatic t_cks();
    logic [103:0] t;
    for (int i = 0; i < 13; i++) t[8*i +: 8] = 8'(i + 1);
    @(posedge clk);
    cfg <= t;
    wr_reg(ADDR_CKSUM_TEST, {CKS_OCTETS, 6'h00});
    tick(3);
    chk({8'h00, cks}, 16'h005B);
    @(posedge clk);
    cfg <= {88'h0, 8'h35, 8'hA5};
    wr_reg(ADDR_CKSUM_TEST, {CKS_FIELDS, 6'h00});
    tick(3);
    chk({8'h00, cks}, 16'h00AD);
    wr_reg(ADDR_CKSUM_TEST, {CKS_ZERO, 6'h00});
    tick(3);
    chk({8'h00, cks}, 16'h0000);
    wr_reg(ADDR_CKSUM_TEST, 8'hC0);
    tick(3);
    chk({8'h00, cks}, 16'h0000);
    $display("checksum test done");
  endtask

  task automatic t_pat();
    logic [15:0] a;
    alt(INJ_SAMPLE, TP_CHECKER, CHECKER_A);
    alt(INJ_SYMBOL, TP_CHECKER, CHECKER_A);
    alt(INJ_SCRAMBLER, TP_CHECKER, CHECKER_A);
    alt(INJ_SAMPLE, TP_TOGGLE, WORD_ONES);
    wr_reg(ADDR_CKSUM_TEST, {4'h0, TP_RAMP});
    tick(4);
    a = smp_out;
    tick(1);
    chk(smp_out, a + 16'h0001);
    wr_reg(ADDR_USER_LO, 8'h34);
    wr_reg(ADDR_USER_HI, 8'h12);
    wr_reg(ADDR_CKSUM_TEST, {4'h0, TP_USER_REP});
    tick(4);
    chk(smp_out, 16'h1234);
    tick(1);
    chk(smp_out, 16'h1234);
    wr_reg(ADDR_CKSUM_TEST, {4'h0, TP_USER_ONE});
    tick(2);
    chk(smp_out, 16'h1234);
    tick(1);
    chk(smp_out, 16'h0000);
    tick(5);
    chk(smp_out, 16'h0000);
    rchk(ADDR_STATUS, 8'h09);
    wr_reg(ADDR_CKSUM_TEST, {4'h0, TP_OFF});
    tick(3);
    chk(smp_out, smp_data);
    chk({8'h00, scr_out}, {8'h00, scr_data});
    chk({6'h00, sym_out}, {6'h00, enc_sym});
    $display("pattern test done");
  endtask

  // Each sequence must obey its own recurrence over six consecutive words.
  task automatic t_pn();
    int len[5] = '{31, 23, 15, 9, 7};
    int tp2[5] = '{28, 18, 14, 5, 6};
    logic [95:0] bits;
    logic [15:0] errs;
    for (int c = 0; c < 5; c++) begin
      wr_reg(ADDR_CKSUM_TEST, {4'h0, TP_PN31 + 4'(c)});
      tick(4);
      for (int w = 0; w < 6; w++) begin
        for (int j = 0; j < 16; j++) bits[w*16 + 15 - j] = smp_out[j];
        tick(1);
      end
      errs = 16'h0000;
      for (int n = len[c]; n < 96; n++) errs += 16'(bits[n] ^ bits[n-tp2[c]] ^ bits[n-len[c]]);
      chk(errs, 16'h0000);
      chk({15'h0000, |bits}, 16'h0001);
    end
    wr_reg(ADDR_CKSUM_TEST, 8'h00);
    $display("pseudorandom test done");
  endtask

  task automatic t_sync(input logic [3:0] dly);
    want_sync <= 1'b1;
    tick(5);
    chk({15'h0000, send_cgs}, 16'h0001);
    wr_reg(ADDR_ALIGN_DLY, {dly, 4'h0});
    want_sync <= 1'b0;
    tick(5);
    chk({15'h0000, send_cgs}, 16'h0000);
    rchk(ADDR_STATUS, 8'h02);
    for (int k = 0; k <= int'(dly); k++) begin
      @(posedge clk);
      lmfc <= 1'b1;
      @(posedge clk);
      lmfc <= 1'b0;
      #1;
      chk({15'h0000, ilas}, {15'h0000, k == int'(dly)});
      tick(2);
    end
    rchk(ADDR_STATUS, 8'h04);
    $display("alignment delay test done");
  endtask

  task automatic t_sync_opts();
    want_sync <= 1'b1;
    wr_reg(ADDR_ENC_OPT, 8'h20);
    tick(5);
    chk({15'h0000, send_cgs}, 16'h0000);
    want_sync <= 1'b0;
    tick(5);
    chk({15'h0000, send_cgs}, 16'h0001);
    want_sync <= 1'b1;
    wr_reg(ADDR_ENC_OPT, 8'h00);
    tick(5);
    chk({15'h0000, send_cgs}, 16'h0001);
    wr_reg(ADDR_LINK_CTRL, 8'h01);
    tick(3);
    chk({15'h0000, send_cgs}, 16'h0000);
    rchk(ADDR_LINK_CTRL, 8'h01);
    wr_reg(ADDR_LINK_CTRL, 8'h00);
    $display("sync option test done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    lmfc = 1'b0;
    want_sync = 1'b1;
    cfg = '0;
    smp_data = 16'hC3A5;
    scr_data = 8'h5A;
    enc_byte = 8'hC3;
    enc_sym = 10'h2F0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_sym();
    t_cks();
    t_pat();
    t_pn();
    t_sync(4'h0);
    t_sync(4'h9);
    t_sync_opts();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
